/* pllc_cfg.svh */
/*
 * Register map, field positions and reset values of the PLL configuration slice.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef PLLC_CFG_SVH
`define PLLC_CFG_SVH

// serial frame layout
`define PLLC_ADDR_W          15
`define PLLC_INSTR_BITS      5'h10
`define PLLC_DATA_BITS       5'h08

// register offsets
`define PLLC_LF3_ADDR        15'h0089
`define PLLC_CP_ADDR         15'h008A
`define PLLC_OSCDIV_ADDR     15'h008B
`define PLLC_PREDIV_ADDR     15'h008C

// loop filter register 3
`define PLLC_LF3_RES3_BYP    7
`define PLLC_LF3_RES1_BYP    6
`define PLLC_LF3_CAP2_BYP    5
`define PLLC_LF3_CAP1_BYP    4
`define PLLC_LF3_RES3_MSB    3
`define PLLC_LF3_RES3_LSB    0
`define PLLC_LF3_BYP_RST     1'h0
`define PLLC_LF3_RES3_RST    4'h8

// charge pump register
`define PLLC_CP_CUR_MSB      5
`define PLLC_CP_CUR_LSB      0
`define PLLC_CP_CUR_RST      6'h20

// oscillator divider register
`define PLLC_OSCDIV_MSB      1
`define PLLC_OSCDIV_LSB      0
`define PLLC_OSCDIV_RST      2'h2

// reference pre-divider register
`define PLLC_PREDIV_MSB      2
`define PLLC_PREDIV_LSB      0
`define PLLC_PREDIV_RST      3'h1

// smallest legal integer feedback word
`define PLLC_FB_WORD_MIN     8'h06

`endif

/* pllc_pkg.sv */
/*
 * Types shared by the PLL configuration slice.
 * Assumes pllc_cfg.svh is compiled alongside.
 */
package pllc_pkg;

   typedef enum logic [1:0]
   {
      PLLC_SPI_IDLE,
      PLLC_SPI_INSTR,
      PLLC_SPI_DATA,
      PLLC_SPI_DONE
   } pllc_spi_state_t;

   typedef logic [7:0] pllc_byte_t;

endpackage

/* pllc_spi_port.sv */
/*
 * Serial control port engine: 16-bit instruction (read flag, 15-bit address), then one data byte, MSB first.
 * Assumes sclk, cs_n and sdi are synchronous to clk and sclk is far slower than clk; sample on sclk rise.
 */
`timescale 1ns/1ps
`include "pllc_cfg.svh"

module pllc_spi_port
   import pllc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    spi_sclk,
   input  wire logic                    spi_cs_n,
   input  wire logic                    spi_sdi,
   output logic                         spi_sdo,
   output logic                         spi_sdo_oe,
   output logic                         reg_wr_stb,
   output logic [`PLLC_ADDR_W-1:0]      reg_addr,
   output logic [7:0]                   reg_wdata,
   input  wire pllc_byte_t              reg_rdata
);

   pllc_spi_state_t         state_ff;
   logic                    sclk_prev_ff;
   logic [4:0]              cnt_ff;
   logic [15:0]             instr_ff;
   logic [7:0]              wdata_ff;
   logic [7:0]              out_ff;
   logic                    is_read_ff;
   logic                    loaded_ff;
   logic                    wr_stb_ff;
   logic [`PLLC_ADDR_W-1:0] addr_ff;
   logic                    sclk_rise;
   logic                    sclk_fall;

   assign sclk_rise = spi_sclk & ~sclk_prev_ff & ~spi_cs_n;
   assign sclk_fall = ~spi_sclk & sclk_prev_ff & ~spi_cs_n;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sclk_prev_ff <= 1'b0;
      else
         sclk_prev_ff <= spi_sclk;
   end

   // frame sequencing; raising cs_n aborts any partial frame without a write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff   <= PLLC_SPI_IDLE;
         cnt_ff     <= 5'h00;
         instr_ff   <= 16'h0000;
         wdata_ff   <= 8'h00;
         is_read_ff <= 1'b0;
         addr_ff    <= '0;
         wr_stb_ff  <= 1'b0;
      end
      else
      begin
         wr_stb_ff <= 1'b0;
         if (spi_cs_n)
         begin
            state_ff <= PLLC_SPI_IDLE;
            cnt_ff   <= 5'h00;
         end
         else
         begin
            unique case (state_ff)
               PLLC_SPI_IDLE:
               begin
                  state_ff <= PLLC_SPI_INSTR;
                  cnt_ff   <= 5'h00;
               end
               PLLC_SPI_INSTR:
               begin
                  if (sclk_rise)
                  begin
                     instr_ff <= {instr_ff[14:0], spi_sdi};
                     cnt_ff   <= cnt_ff + 5'h01;
                     if (cnt_ff == `PLLC_INSTR_BITS - 5'h01)
                     begin
                        is_read_ff <= instr_ff[14];
                        addr_ff    <= {instr_ff[13:0], spi_sdi};
                        cnt_ff     <= 5'h00;
                        state_ff   <= PLLC_SPI_DATA;
                     end
                  end
               end
               PLLC_SPI_DATA:
               begin
                  if (sclk_rise)
                  begin
                     wdata_ff <= {wdata_ff[6:0], spi_sdi};
                     cnt_ff   <= cnt_ff + 5'h01;
                     if (cnt_ff == `PLLC_DATA_BITS - 5'h01)
                     begin
                        wr_stb_ff <= ~is_read_ff;
                        state_ff  <= PLLC_SPI_DONE;
                     end
                  end
               end
               PLLC_SPI_DONE:
               begin
                  // extra clocks in the frame are ignored
                  state_ff <= PLLC_SPI_DONE;
               end
            endcase
         end
      end
   end

   // readback: load on the first falling edge after the address, shift on later ones
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         out_ff    <= 8'h00;
         loaded_ff <= 1'b0;
      end
      else if (spi_cs_n)
      begin
         loaded_ff <= 1'b0;
      end
      else if (state_ff == PLLC_SPI_DATA && is_read_ff && sclk_fall)
      begin
         if (!loaded_ff)
         begin
            out_ff    <= reg_rdata;
            loaded_ff <= 1'b1;
         end
         else
            out_ff <= {out_ff[6:0], 1'b0};
      end
   end

   assign spi_sdo    = out_ff[7];
   assign spi_sdo_oe = loaded_ff & ~spi_cs_n;
   assign reg_wr_stb = wr_stb_ff;
   assign reg_addr   = addr_ff;
   assign reg_wdata  = wdata_ff;

endmodule

/* pllc_regs.sv */
/*
 * PLL configuration register slice: loop filter 3, charge pump, oscillator divider, reference pre-divider.
 * Assumes the serial port pins are synchronous to clk; res1, cap2 and cap1 filter words and feedback word come from outside.
 */
// Notes on behaviour
// R1 - bit 7 bypasses resistor three when word zero
// R2 - bit 6 bypasses resistor one when word zero
// R3 - bit 5 bypasses capacitor two when word zero
// R4 - bit 4 bypasses capacitor one when word zero
// R5 - resistor three word bits 3:0, reset 0x8
// R6 - pump current bits 5:0, reset 0x20
// R7 - divider select reset 2: 4, 8, 16
// R8 - software keeps oscillator between 6 and 12 GHz
// R9 - reference pre-divider bits 2:0, reset 1
// R10 - software keeps reference within 35-80 MHz
// R11 - converter clock is ref/prediv times 2B
// R12 - reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "pllc_cfg.svh"

module pllc_regs
   import pllc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       spi_sclk,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_sdi,
   output logic            spi_sdo,
   output logic            spi_sdo_oe,
   input  wire logic [3:0] filter_res1_value,
   input  wire logic [3:0] filter_cap2_value,
   input  wire logic [3:0] filter_cap1_value,
   input  wire logic [7:0] feedback_word,
   output logic            filter_res3_bypass,
   output logic            filter_res1_bypass,
   output logic            filter_cap2_bypass,
   output logic            filter_cap1_bypass,
   output logic [3:0]      filter_res3_value,
   output logic [5:0]      pump_current_sel,
   output logic [1:0]      osc_to_conv_divider,
   output logic [2:0]      ref_prediv_sel,
   output logic [4:0]      osc_div_ratio,
   output logic            osc_div_valid,
   output logic [4:0]      ref_div_ratio,
   output logic            ref_div_valid,
   output logic [8:0]      feedback_mult,
   output logic            feedback_word_ok
);

   logic [3:0]              byp_ff;
   logic [3:0]              res3_ff;
   logic [5:0]              pump_ff;
   logic [1:0]              oscdiv_ff;
   logic [2:0]              prediv_ff;
   logic                    wr_stb;
   logic [`PLLC_ADDR_W-1:0] reg_addr;
   logic [7:0]              reg_wdata;
   pllc_byte_t              reg_rdata;
   logic                    bypass_c1_ff;
   logic                    bypass_c2_ff;
   logic                    bypass_r1_ff;
   logic                    bypass_r3_ff;
   logic [4:0]              osc_ratio_ff;
   logic [4:0]              ref_ratio_ff;
   logic                    osc_ok_ff;
   logic                    ref_ok_ff;
   logic [8:0]              fb_mult_ff;
   logic                    fb_ok_ff;

   function automatic logic is_zero(input logic [3:0] w);
      return w == 4'h0;
   endfunction

   function automatic logic hit(input logic [`PLLC_ADDR_W-1:0] a, input logic [`PLLC_ADDR_W-1:0] r);
      return wr_stb && a == r;
   endfunction

   pllc_spi_port u_spi
   (
      .clk        (clk),
      .rst        (rst),
      .spi_sclk   (spi_sclk),
      .spi_cs_n   (spi_cs_n),
      .spi_sdi    (spi_sdi),
      .spi_sdo    (spi_sdo),
      .spi_sdo_oe (spi_sdo_oe),
      .reg_wr_stb (wr_stb),
      .reg_addr   (reg_addr),
      .reg_wdata  (reg_wdata),
      .reg_rdata  (reg_rdata)
   );

   // bypass bits {r3, r1, c2, c1} sit in bits 7:4
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         byp_ff  <= {4{`PLLC_LF3_BYP_RST}};
         res3_ff <= `PLLC_LF3_RES3_RST; // R5
      end
      else if (hit(reg_addr, `PLLC_LF3_ADDR))
      begin
         byp_ff  <= {reg_wdata[`PLLC_LF3_RES3_BYP], reg_wdata[`PLLC_LF3_RES1_BYP],
                     reg_wdata[`PLLC_LF3_CAP2_BYP], reg_wdata[`PLLC_LF3_CAP1_BYP]};
         res3_ff <= reg_wdata[`PLLC_LF3_RES3_MSB:`PLLC_LF3_RES3_LSB]; // R5
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pump_ff <= `PLLC_CP_CUR_RST; // R6
      else if (hit(reg_addr, `PLLC_CP_ADDR))
         pump_ff <= reg_wdata[`PLLC_CP_CUR_MSB:`PLLC_CP_CUR_LSB]; // R6
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         oscdiv_ff <= `PLLC_OSCDIV_RST; // R7
      else if (hit(reg_addr, `PLLC_OSCDIV_ADDR))
         oscdiv_ff <= reg_wdata[`PLLC_OSCDIV_MSB:`PLLC_OSCDIV_LSB]; // R7
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prediv_ff <= `PLLC_PREDIV_RST; // R9
      else if (hit(reg_addr, `PLLC_PREDIV_ADDR))
         prediv_ff <= reg_wdata[`PLLC_PREDIV_MSB:`PLLC_PREDIV_LSB]; // R9
   end

   // readback; unmapped addresses and reserved bits give zero
   always_comb
   begin
      reg_rdata = 8'h00;
      unique case (reg_addr)
         `PLLC_LF3_ADDR:    reg_rdata = {byp_ff, res3_ff};
         `PLLC_CP_ADDR:     reg_rdata = {2'h0, pump_ff};   // R12
         `PLLC_OSCDIV_ADDR: reg_rdata = {6'h00, oscdiv_ff}; // R12
         `PLLC_PREDIV_ADDR: reg_rdata = {5'h00, prediv_ff}; // R12
         default:           reg_rdata = 8'h00;             // R12
      endcase
   end

   // a bypass only takes effect while the matching element word is zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bypass_r3_ff <= 1'b0;
         bypass_r1_ff <= 1'b0;
         bypass_c2_ff <= 1'b0;
         bypass_c1_ff <= 1'b0;
      end
      else
      begin
         bypass_r3_ff <= byp_ff[3] & is_zero(res3_ff);           // R1
         bypass_r1_ff <= byp_ff[2] & is_zero(filter_res1_value); // R2
         bypass_c2_ff <= byp_ff[1] & is_zero(filter_cap2_value); // R3
         bypass_c1_ff <= byp_ff[0] & is_zero(filter_cap1_value); // R4
      end
   end

   // ratio decode; code 00 of the divider select has no ratio and reads as invalid
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         osc_ratio_ff <= 5'h08;
         osc_ok_ff    <= 1'b1;
      end
      else
      begin
         unique case (oscdiv_ff) // R7
            2'h1:    osc_ratio_ff <= 5'h04;
            2'h2:    osc_ratio_ff <= 5'h08;
            2'h3:    osc_ratio_ff <= 5'h10;
            default: osc_ratio_ff <= 5'h00;
         endcase
         osc_ok_ff <= oscdiv_ff != 2'h0; // R7
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ref_ratio_ff <= 5'h02;
         ref_ok_ff    <= 1'b1;
      end
      else
      begin
         unique case (prediv_ff) // R9
            3'h0:    ref_ratio_ff <= 5'h01;
            3'h1:    ref_ratio_ff <= 5'h02;
            3'h2:    ref_ratio_ff <= 5'h04;
            3'h3:    ref_ratio_ff <= 5'h08;
            3'h4:    ref_ratio_ff <= 5'h10;
            default: ref_ratio_ff <= 5'h00;
         endcase
         ref_ok_ff <= prediv_ff <= 3'h4; // R9
      end
   end

   // feedback multiplication is twice the integer word, which must be at least six
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fb_mult_ff <= 9'h000;
         fb_ok_ff   <= 1'b0;
      end
      else
      begin
         fb_mult_ff <= {feedback_word, 1'b0};                  // R11
         fb_ok_ff   <= feedback_word >= `PLLC_FB_WORD_MIN;      // R11
      end
   end

   assign filter_res3_bypass  = bypass_r3_ff;
   assign filter_res1_bypass  = bypass_r1_ff;
   assign filter_cap2_bypass  = bypass_c2_ff;
   assign filter_cap1_bypass  = bypass_c1_ff;
   assign filter_res3_value   = res3_ff;
   assign pump_current_sel    = pump_ff;
   assign osc_to_conv_divider = oscdiv_ff;
   assign ref_prediv_sel      = prediv_ff;
   assign osc_div_ratio       = osc_ratio_ff;
   assign osc_div_valid       = osc_ok_ff;
   assign ref_div_ratio       = ref_ratio_ff;
   assign ref_div_valid       = ref_ok_ff;
   assign feedback_mult       = fb_mult_ff;
   assign feedback_word_ok    = fb_ok_ff;

endmodule

/* pllc_regs_properties.sv */
/*
 * Concurrent checks on the ports of the PLL configuration slice.
 * Assumes binding to pllc_regs; one clock, async active-high reset.
 */
`timescale 1ns/1ps

module pllc_regs_props
   import pllc_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [3:0] filter_res1_value,
   input wire logic [3:0] filter_cap2_value,
   input wire logic [3:0] filter_cap1_value,
   input wire logic [7:0] feedback_word,
   input wire logic       filter_res3_bypass,
   input wire logic       filter_res1_bypass,
   input wire logic       filter_cap2_bypass,
   input wire logic       filter_cap1_bypass,
   input wire logic [3:0] filter_res3_value,
   input wire logic [5:0] pump_current_sel,
   input wire logic [1:0] osc_to_conv_divider,
   input wire logic [2:0] ref_prediv_sel,
   input wire logic [4:0] osc_div_ratio,
   input wire logic       osc_div_valid,
   input wire logic [4:0] ref_div_ratio,
   input wire logic       ref_div_valid,
   input wire logic [8:0] feedback_mult,
   input wire logic       feedback_word_ok
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // bypass bit itself is internal, so only the word gating is visible here
   a_res3_bypass_gate: assert property (filter_res3_bypass |-> $past(filter_res3_value) == 4'h0)
      else $error("res3 bypass with nonzero word");
   a_res1_bypass_gate: assert property (filter_res1_bypass |-> $past(filter_res1_value) == 4'h0)
      else $error("res1 bypass with nonzero word");
   a_cap2_bypass_gate: assert property (filter_cap2_bypass |-> $past(filter_cap2_value) == 4'h0)
      else $error("cap2 bypass with nonzero word");
   a_cap1_bypass_gate: assert property (filter_cap1_bypass |-> $past(filter_cap1_value) == 4'h0)
      else $error("cap1 bypass with nonzero word");
   a_reset_field_values: assert property ($fell(rst) |-> filter_res3_value == 4'h8 &&
      pump_current_sel == 6'h20 && osc_to_conv_divider == 2'h2 && ref_prediv_sel == 3'h1)
      else $error("field reset values wrong");
   a_osc_ratio_map: assert property (osc_to_conv_divider != 2'h0 |=>
      osc_div_valid && osc_div_ratio == (5'h02 << $past(osc_to_conv_divider)))
      else $error("oscillator ratio wrong");
   a_osc_code_undefined: assert property (osc_to_conv_divider == 2'h0 |=> !osc_div_valid && osc_div_ratio == 5'h00)
      else $error("oscillator code zero flagged valid");
   a_ref_ratio_map: assert property (ref_prediv_sel <= 3'h4 |=>
      ref_div_valid && ref_div_ratio == (5'h01 << $past(ref_prediv_sel)))
      else $error("reference ratio wrong");
   a_ref_code_undefined: assert property (ref_prediv_sel > 3'h4 |=> !ref_div_valid && ref_div_ratio == 5'h00)
      else $error("undefined prediv code flagged valid");
   a_feedback_product: assert property (1'b1 |=> feedback_mult == {$past(feedback_word), 1'b0} &&
      feedback_word_ok == ($past(feedback_word) >= 8'h06))
      else $error("feedback product or minimum flag wrong");
endmodule

bind pllc_regs pllc_regs_props i_pllc_regs_props (.clk, .rst, .filter_res1_value, .filter_cap2_value,
   .filter_cap1_value, .feedback_word, .filter_res3_bypass, .filter_res1_bypass, .filter_cap2_bypass,
   .filter_cap1_bypass, .filter_res3_value, .pump_current_sel, .osc_to_conv_divider, .ref_prediv_sel,
   .osc_div_ratio, .osc_div_valid, .ref_div_ratio, .ref_div_valid, .feedback_mult, .feedback_word_ok);

/* tb_top.sv */
/*
 * Self-checking bench for pllc_regs: serial register access and derived outputs.
 * Assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/1ps
`include "pllc_cfg.svh"

module tb_top
   import pllc_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       sclk = 1'b0;
   logic       cs_n = 1'b1;
   logic       sdi = 1'b0;
   logic [3:0] r1v = 4'h0;
   logic [3:0] c2v = 4'h0;
   logic [3:0] c1v = 4'h0;
   logic [7:0] fbw = 8'h00;
   logic [7:0] v;
   pllc_byte_t got;
   logic       sdo, sdo_oe, b3, b1, bc2, bc1, odv, rdv, fbok;
   logic [3:0] r3v;
   logic [5:0] pc;
   logic [1:0] od;
   logic [2:0] pd;
   logic [4:0] odr, rdr;
   logic [8:0] fbm;
   int         bad_count = 0;
   int         samples_checked = 0;
   int         osc_r[4] = '{0, 4, 8, 16};
   int         ref_r[8] = '{1, 2, 4, 8, 16, 0, 0, 0};
   pllc_byte_t exp_q[$];
   int         nbits = 0;

   always #10 clk = ~clk;

   pllc_regs i_pllc_regs (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
      .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .filter_res1_value(r1v), .filter_cap2_value(c2v),
      .filter_cap1_value(c1v), .feedback_word(fbw), .filter_res3_bypass(b3), .filter_res1_bypass(b1),
      .filter_cap2_bypass(bc2), .filter_cap1_bypass(bc1), .filter_res3_value(r3v),
      .pump_current_sel(pc), .osc_to_conv_divider(od), .ref_prediv_sel(pd), .osc_div_ratio(odr),
      .osc_div_valid(odv), .ref_div_ratio(rdr), .ref_div_valid(rdv), .feedback_mult(fbm),
      .feedback_word_ok(fbok));

   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk_out(input logic [8:0] e, input logic [8:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_rd(input pllc_byte_t e, input pllc_byte_t g);
      chk_out({1'b0, e}, {1'b0, g});
   endtask

   // mode 0 frame of n clocks; low phase 3 clk so sdo has settled before the rise
   task automatic spi(input logic rd, input logic [14:0] a, input pllc_byte_t d, input int n);
      logic [23:0] f;
      f = {rd, a, d};
      @(negedge clk);
      cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         sdi = f[23];
         f = {f[22:0], 1'b1};
         sclk = 1'b0;
         repeat (3) @(negedge clk);
         sclk = 1'b1;
         repeat (2) @(negedge clk);
      end
      sclk = 1'b0;
      repeat (2) @(negedge clk);
      cs_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask

   task automatic wr(input logic [14:0] a, input pllc_byte_t d);
      spi(1'b0, a, d, 24);
   endtask

   task automatic rd(input logic [14:0] a, input pllc_byte_t e);
      exp_q.push_back(e);
      spi(1'b1, a, 8'h00, 24);
   endtask

   // read data rebuilt from sdo at each sclk rise while the device drives it
   always @(posedge sclk)
   begin
      if (sdo_oe === 1'b1)
      begin
         got = {got[6:0], sdo};
         nbits++;
         if (nbits == 8)
         begin
            nbits = 0;
            chk_rd(exp_q.pop_front(), got);
         end
      end
   end

   initial
   begin
      void'($urandom(32'hC7A0));
      repeat (5) @(negedge clk);
      rst = 1'b0;
      rd(`PLLC_LF3_ADDR, 8'h08);
      rd(`PLLC_CP_ADDR, 8'h20);
      rd(`PLLC_OSCDIV_ADDR, 8'h02);
      rd(`PLLC_PREDIV_ADDR, 8'h01);
      chk_out({1'b0, b3, b1, bc2, bc1, r3v}, 9'h008);
      wr(`PLLC_CP_ADDR, 8'hFF);
      rd(`PLLC_CP_ADDR, 8'h3F);
      // a frame cut short writes nothing; clocks after the 24th are ignored
      spi(1'b0, `PLLC_CP_ADDR, 8'h15, 20);
      rd(`PLLC_CP_ADDR, 8'h3F);
      spi(1'b0, `PLLC_CP_ADDR, 8'h15, 27);
      rd(`PLLC_CP_ADDR, 8'h15);
      wr(`PLLC_OSCDIV_ADDR, 8'hFF);
      rd(`PLLC_OSCDIV_ADDR, 8'h03);
      wr(`PLLC_PREDIV_ADDR, 8'hFF);
      rd(`PLLC_PREDIV_ADDR, 8'h07);
      wr(15'h008D, 8'h5A);
      rd(15'h008D, 8'h00);
      // even passes force zero words so every bypass can assert
      for (int i = 0; i < 8; i++)
      begin
         v = $urandom;
         r1v = i[0] ? 4'($urandom) : 4'h0;
         c2v = i[0] ? 4'($urandom) : 4'h0;
         c1v = i[0] ? 4'($urandom) : 4'h0;
         if (!i[0])
            v[3:0] = 4'h0;
         wr(`PLLC_LF3_ADDR, v);
         rd(`PLLC_LF3_ADDR, v);
         chk_out({5'h00, b3, b1, bc2, bc1}, {5'h00, v[7] & (v[3:0] == 4'h0), v[6] & (r1v == 4'h0),
            v[5] & (c2v == 4'h0), v[4] & (c1v == 4'h0)});
      end
      for (int c = 0; c < 4; c++)
      begin
         wr(`PLLC_OSCDIV_ADDR, 8'(c));
         chk_out({odv, 3'h0, odr}, {c != 0, 3'h0, 5'(osc_r[c])});
      end
      for (int c = 0; c < 8; c++)
      begin
         wr(`PLLC_PREDIV_ADDR, 8'(c));
         chk_out({rdv, 3'h0, rdr}, {c < 5, 3'h0, 5'(ref_r[c])});
      end
      for (int i = 0; i < 8; i++)
      begin
         fbw = (i < 4) ? 8'(4 + i) : 8'($urandom);
         repeat (3) @(negedge clk);
         chk_out(fbm, {fbw, 1'b0});
         chk_out({8'h00, fbok}, {8'h00, fbw >= 8'h06});
      end
      // recommended settings; divider codes picked for legal oscillator and reference windows
      wr(`PLLC_LF3_ADDR, 8'h0E);
      wr(`PLLC_CP_ADDR, 8'h12);
      wr(`PLLC_OSCDIV_ADDR, 8'h01);
      wr(`PLLC_PREDIV_ADDR, 8'h02);
      rd(`PLLC_CP_ADDR, 8'h12);
      chk_out({r3v, od, pd}, {4'hE, 2'h1, 3'h2});
      chk_out({3'h0, pc}, 9'h012);
      // second reset in mid-run must restore every field
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      chk_out({r3v, od, pd}, {4'h8, 2'h2, 3'h1});
      chk_out({3'h0, pc}, 9'h020);
      chk_out({odv, 3'h0, odr}, {1'b1, 3'h0, 5'h08});
      chk_out({rdv, 3'h0, rdr}, {1'b1, 3'h0, 5'h02});
      rd(`PLLC_LF3_ADDR, 8'h08);
      chk_out(9'(exp_q.size()), 9'h000);
      complete_run();
   end

   // about four times the expected run length
   initial
   begin
      #500000;
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule
